// [hdl/ofm_pkg.sv]
// Purpose: shared constants and types for the oil flow meter display logic
// Assumes: 100 MHz pclk, APB register access, one-second timebase
// Notes:   times are held in seconds, days or ns and turned into counts below
package ofm_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HALF_TICK_NS  = 500_000_000;
  localparam int unsigned HALF_S_CYC    = HALF_TICK_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  SUM_BLINK_S   = 6'd5;
  localparam logic [5:0]  SUM_CLR_S     = 6'd10;
  localparam logic [5:0]  FLOW_BLINK_S  = 6'd25;
  localparam logic [5:0]  PRESET_MIN_S  = 6'd30;
  localparam logic [5:0]  PRESET_MAX_S  = 6'd32;
  localparam logic [2:0]  CONFIRM_S     = 3'd5;
  localparam int unsigned BLANK_DAYS    = 2;
  localparam int unsigned BLANK_AFTER_S = BLANK_DAYS * 24 * 3600;
  localparam int unsigned BATT_HOLD_S   = 2 * 60;
  localparam int unsigned SEC_PER_HOUR  = 3600;
  localparam int unsigned FLOW_WIN_S    = 4;
  localparam int unsigned PULSE_PER_L   = 500;
  localparam logic [6:0]  LOW_PCT       = 7'd10;
  localparam logic [19:0] VALUE_MAX     = 20'hf423f;

  // apb map (byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_FLOW    = 8'h08;
  localparam logic [7:0] OFS_NOM1    = 8'h0c;
  localparam logic [7:0] OFS_NOM2    = 8'h10;
  localparam logic [7:0] OFS_SUMVOL  = 8'h14;
  localparam logic [7:0] OFS_TOTVOL  = 8'h18;
  localparam logic [7:0] OFS_HOURS1  = 8'h1c;
  localparam logic [7:0] OFS_HOURS2  = 8'h20;
  localparam logic [7:0] OFS_STARTS1 = 8'h24;
  localparam logic [7:0] OFS_STARTS2 = 8'h28;

  // control fields
  localparam int unsigned CTRL_TWO_STAGE = 0;
  localparam int unsigned CTRL_SWITCH2   = 1;
  localparam int unsigned CTRL_BATT_VAR  = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;

  // display units
  localparam logic [1:0] UNIT_LPH   = 2'h0;
  localparam logic [1:0] UNIT_L     = 2'h1;
  localparam logic [1:0] UNIT_H     = 2'h2;
  localparam logic [1:0] UNIT_COUNT = 2'h3;

  typedef enum logic [9:0] {
    MODE_FLOW1   = 10'h001,
    MODE_FLOW2   = 10'h002,
    MODE_SUM     = 10'h004,
    MODE_TOTAL   = 10'h008,
    MODE_HRS1    = 10'h010,
    MODE_STARTS1 = 10'h020,
    MODE_HRS2    = 10'h040,
    MODE_STARTS2 = 10'h080,
    MODE_SVC     = 10'h100,
    MODE_BATT    = 10'h200
  } ofm_mode_t;

  localparam logic [9:0] SINGLE_MASK = 10'h31d;
  localparam logic [9:0] DUAL_MASK   = 10'h3ff;

endpackage

// [hdl/ofm_tick_if.sv]
// Purpose: timebase strobes from the divider to the display logic
// Assumes: sec_tick is one pclk cycle wide
// Notes:   blink is a level, high in the visible half of each second
`timescale 1ns/1ps
interface ofm_tick_if;
  logic sec_tick;
  logic blink;
  modport src (output sec_tick, output blink);
  modport snk (input sec_tick, input blink);
endinterface

// [hdl/ofm_tick.sv]
// Purpose: divides pclk into a one-second enable and a blink phase
// Assumes: HALF_CYC is the number of pclk cycles in half a second
// Notes:   shorten HALF_CYC in simulation
`timescale 1ns/1ps
module ofm_tick #(
  parameter int unsigned HALF_CYC = ofm_pkg::HALF_S_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // strobes
  ofm_tick_if.src   tk
);

  logic [31:0] div_ff;
  logic        phase_ff;
  logic        sec_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_ff   <= 32'h0;
      phase_ff <= 1'b0;
      sec_ff   <= 1'b0;
    end
    else if (div_ff == HALF_CYC - 1)
    begin
      div_ff   <= 32'h0;
      phase_ff <= ~phase_ff;
      sec_ff   <= phase_ff;
    end
    else
    begin
      div_ff <= div_ff + 32'h1;
      sec_ff <= 1'b0;
    end
  end

  assign tk.sec_tick = sec_ff;
  assign tk.blink    = ~phase_ff;

endmodule

// [hdl/ofm_top.sv]
// Purpose: flow meter display logic with counters, presets and apb access
// Assumes: field inputs synchronous to pclk; one sensor pulse per edge
// Notes:   counters other than the sum reset only by presetn, standing for a cold start
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module ofm_top #(
  parameter int unsigned HALF_CYC     = ofm_pkg::HALF_S_CYC,
  parameter int unsigned BLANK_S      = ofm_pkg::BLANK_AFTER_S,
  parameter int unsigned PULSE_PER_L  = ofm_pkg::PULSE_PER_L,
  parameter int unsigned FLOW_WIN_S   = ofm_pkg::FLOW_WIN_S,
  parameter int unsigned SEC_PER_HOUR = ofm_pkg::SEC_PER_HOUR
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // field inputs
  input  wire logic        flow_pulse,
  input  wire logic        button_n,
  input  wire logic        stage1_run,
  input  wire logic        stage2_run,
  input  wire logic        mains_ok,
  input  wire logic        batt_low,
  // display
  output logic      [19:0] disp_value,
  output logic      [5:0]  digit_on,
  output logic             dec2,
  output logic      [1:0]  disp_unit,
  output logic      [9:0]  mode_sym,
  output logic             svc_sym,
  output logic             batt_sym
);

  ofm_tick_if tk ();

  ofm_tick #(
    .HALF_CYC (HALF_CYC)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tk)
  );

  logic [2:0]  ctrl_ff;
  logic        btn_d_ff;
  logic        pulse_d_ff;
  logic        run1_d_ff;
  logic        run2_d_ff;
  logic [5:0]  hold_ff;
  logic [2:0]  conf_ff;
  logic        conf_zero_ff;
  logic        conf_stage2_ff;
  logic [19:0] flow_ff;
  logic [19:0] win_cnt_ff;
  logic [7:0]  win_sec_ff;
  logic [15:0] pdiv_ff;
  logic [19:0] sum_ff;
  logic [19:0] tot_ff;
  logic [19:0] nom1_ff;
  logic [19:0] nom2_ff;
  logic [11:0] hsec1_ff;
  logic [11:0] hsec2_ff;
  logic [19:0] hrs1_ff;
  logic [19:0] hrs2_ff;
  logic [19:0] st1_ff;
  logic [19:0] st2_ff;
  logic        svc_ff;
  logic [17:0] loss_ff;
  logic [19:0] disp_value_ff;
  logic [5:0]  digit_on_ff;
  logic        dec2_ff;
  logic [1:0]  unit_ff;
  logic        svc_sym_ff;
  logic        batt_sym_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;

  ofm_pkg::ofm_mode_t mode_ff;

  logic        two_stage;
  logic        batt_var;
  logic        btn;
  logic        release_evt;
  logic        ops_ok;
  logic        in_flow;
  logic        do_next;
  logic        do_clr_sum;
  logic        do_store;
  logic        do_clear_nom;
  logic        litre;
  logic        blink_hold;
  logic        confirming;
  logic        disp_lit;
  logic [9:0]  allow;
  logic [19:0] nom_act;
  logic [19:0] nxt_value;
  logic [1:0]  nxt_unit;
  logic        nxt_dec2;
  logic [5:0]  nxt_digit_on;
  logic        apb_access;
  logic        hit;

  function automatic logic [19:0] inc_wrap(input logic [19:0] v);
    inc_wrap = (v == ofm_pkg::VALUE_MAX) ? 20'h0 : v + 20'h1;
  endfunction

  function automatic logic [9:0] next_mode(input logic [9:0] cur,
                                           input logic [9:0] msk);
    logic [9:0] r;
    logic       found;
    next_mode = cur;
    r         = cur;
    found     = 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      r = {r[8:0], r[9]};
      if (!found && |(r & msk))
      begin
        next_mode = r;
        found     = 1'b1;
      end
    end
  endfunction

  // switch 2 is stored for software but feeds nothing
  assign two_stage = ctrl_ff[ofm_pkg::CTRL_TWO_STAGE];
  assign batt_var  = ctrl_ff[ofm_pkg::CTRL_BATT_VAR];
  assign allow     = two_stage ? ofm_pkg::DUAL_MASK
                               : ofm_pkg::SINGLE_MASK;
  assign btn         = ~button_n;
  assign release_evt = btn_d_ff & ~btn;
  assign ops_ok      = batt_var | mains_ok;
  assign in_flow     = (mode_ff == ofm_pkg::MODE_FLOW1) ||
                       (mode_ff == ofm_pkg::MODE_FLOW2);

  // release decides: short press steps on, long holds are special in the sum and flow modes
  always_comb
  begin
    do_next      = 1'b0;
    do_clr_sum   = 1'b0;
    do_store     = 1'b0;
    do_clear_nom = 1'b0;
    if (release_evt)
    begin
      if (mode_ff == ofm_pkg::MODE_SUM)
      begin
        do_next    = hold_ff < ofm_pkg::SUM_BLINK_S;
        do_clr_sum = ops_ok && hold_ff >= ofm_pkg::SUM_CLR_S;
      end
      else if (in_flow)
      begin
        do_next  = hold_ff < ofm_pkg::FLOW_BLINK_S;
        do_store = ops_ok && hold_ff >= ofm_pkg::PRESET_MIN_S &&
                   hold_ff < ofm_pkg::PRESET_MAX_S;
        do_clear_nom = ops_ok &&
                       hold_ff >= ofm_pkg::PRESET_MAX_S;
      end
      else
        do_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      btn_d_ff   <= 1'b0;
      pulse_d_ff <= 1'b0;
      run1_d_ff  <= 1'b0;
      run2_d_ff  <= 1'b0;
    end
    else
    begin
      btn_d_ff   <= btn;
      pulse_d_ff <= flow_pulse;
      run1_d_ff  <= stage1_run;
      run2_d_ff  <= stage2_run;
    end
  end

  // mode steps on at release, falls back to MODE_FLOW1 when not allowed, and otherwise holds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_ff <= ofm_pkg::MODE_FLOW1;
    else if (do_next)
      mode_ff <= ofm_pkg::ofm_mode_t'(next_mode(mode_ff, allow));
    else if (!(|(mode_ff & allow)))
      mode_ff <= ofm_pkg::MODE_FLOW1;
  end

  // whole seconds held, saturating so long holds stay long
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_ff <= 6'h0;
    else if (btn && !btn_d_ff)
      hold_ff <= 6'h0;
    else if (btn && tk.sec_tick && hold_ff != 6'h3f)
      hold_ff <= hold_ff + 6'h1;
  end

  // confirmation blink after a preset store or a preset clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conf_ff        <= 3'h0;
      conf_zero_ff   <= 1'b0;
      conf_stage2_ff <= 1'b0;
    end
    else if (do_store || do_clear_nom)
    begin
      conf_ff        <= ofm_pkg::CONFIRM_S;
      conf_zero_ff   <= do_clear_nom;
      conf_stage2_ff <= mode_ff == ofm_pkg::MODE_FLOW2;
    end
    else if (tk.sec_tick && conf_ff != 3'h0)
      conf_ff <= conf_ff - 3'h1;
  end

  // presets per stage; stage 2 preset comes from the stage 2 flow mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nom1_ff <= 20'h0;
      nom2_ff <= 20'h0;
    end
    else if (do_store)
    begin
      if (mode_ff == ofm_pkg::MODE_FLOW2)
        nom2_ff <= flow_ff;
      else
        nom1_ff <= flow_ff;
    end
    else if (do_clear_nom)
    begin
      if (mode_ff == ofm_pkg::MODE_FLOW2)
        nom2_ff <= 20'h0;
      else
        nom1_ff <= 20'h0;
    end
  end

  // flow is pulses per measuring window, one sensor for both stages
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flow_ff    <= 20'h0;
      win_cnt_ff <= 20'h0;
      win_sec_ff <= 8'h0;
    end
    else
    begin
      if (tk.sec_tick && win_sec_ff == 8'(FLOW_WIN_S - 1))
      begin
        flow_ff    <= win_cnt_ff;
        win_cnt_ff <= {19'h0, flow_pulse & ~pulse_d_ff};
        win_sec_ff <= 8'h0;
      end
      else
      begin
        if (flow_pulse && !pulse_d_ff && win_cnt_ff != ofm_pkg::VALUE_MAX)
          win_cnt_ff <= win_cnt_ff + 20'h1;
        if (tk.sec_tick)
          win_sec_ff <= win_sec_ff + 8'h1;
      end
    end
  end

  assign litre = flow_pulse && !pulse_d_ff &&
                 pdiv_ff == 16'(PULSE_PER_L - 1);

  // both volumes count litres; only the sum counter may be cleared
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pdiv_ff <= 16'h0;
      sum_ff  <= 20'h0;
      tot_ff  <= 20'h0;
    end
    else
    begin
      if (flow_pulse && !pulse_d_ff)
        pdiv_ff <= litre ? 16'h0 : pdiv_ff + 16'h1;
      if (litre)
        tot_ff <= inc_wrap(tot_ff);
      if (do_clr_sum)
        sum_ff <= 20'h0;
      else if (litre)
        sum_ff <= inc_wrap(sum_ff);
    end
  end

  // running hours and starts, one set per stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hsec1_ff <= 12'h0;
      hsec2_ff <= 12'h0;
      hrs1_ff  <= 20'h0;
      hrs2_ff  <= 20'h0;
      st1_ff   <= 20'h0;
      st2_ff   <= 20'h0;
    end
    else
    begin
      if (tk.sec_tick && stage1_run)
      begin
        hsec1_ff <= (hsec1_ff == 12'(SEC_PER_HOUR - 1)) ? 12'h0
                                                        : hsec1_ff + 12'h1;
        if (hsec1_ff == 12'(SEC_PER_HOUR - 1))
          hrs1_ff <= inc_wrap(hrs1_ff);
      end
      if (tk.sec_tick && stage2_run)
      begin
        hsec2_ff <= (hsec2_ff == 12'(SEC_PER_HOUR - 1)) ? 12'h0
                                                        : hsec2_ff + 12'h1;
        if (hsec2_ff == 12'(SEC_PER_HOUR - 1))
          hrs2_ff <= inc_wrap(hrs2_ff);
      end
      if (stage1_run && !run1_d_ff)
        st1_ff <= inc_wrap(st1_ff);
      if (stage2_run && !run2_d_ff)
        st2_ff <= inc_wrap(st2_ff);
    end
  end

  // supervision against the preset of the stage now running
  assign nom_act = (two_stage && stage2_run) ? nom2_ff : nom1_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      svc_ff <= 1'b0;
    else if (nom_act == 20'h0)
      svc_ff <= 1'b0;
    else if (tk.sec_tick && stage1_run)
      svc_ff <= 27'(flow_ff) * 27'd100 <
                27'(nom_act) * 27'(7'd100 - ofm_pkg::LOW_PCT);
  end

  // seconds without mains; saturates at the blanking point
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loss_ff <= 18'h0;
    else if (mains_ok || batt_var)
      loss_ff <= 18'h0;
    else if (tk.sec_tick && loss_ff != 18'(BLANK_S))
      loss_ff <= loss_ff + 18'h1;
  end

  assign disp_lit   = loss_ff < 18'(BLANK_S);
  assign confirming = conf_ff != 3'h0;
  assign blink_hold = btn && (((mode_ff == ofm_pkg::MODE_SUM) &&
                       hold_ff >= ofm_pkg::SUM_BLINK_S &&
                       hold_ff < ofm_pkg::SUM_CLR_S) ||
                      (in_flow && hold_ff >= ofm_pkg::FLOW_BLINK_S &&
                       hold_ff < ofm_pkg::PRESET_MIN_S));

  // shown value follows the current mode each cycle, or the preset while confirming
  always_comb
  begin
    nxt_value = 20'h0;
    nxt_unit  = ofm_pkg::UNIT_COUNT;
    nxt_dec2  = 1'b0;
    if (confirming)
    begin
      nxt_value = conf_zero_ff ? 20'h0
                : (conf_stage2_ff ? nom2_ff : nom1_ff);
      nxt_unit  = ofm_pkg::UNIT_LPH;
      nxt_dec2  = 1'b1;
    end
    else
    begin
      unique case (mode_ff)
        ofm_pkg::MODE_FLOW1, ofm_pkg::MODE_FLOW2:
        begin
          nxt_value = flow_ff;
          nxt_unit  = ofm_pkg::UNIT_LPH;
          nxt_dec2  = 1'b1;
        end
        ofm_pkg::MODE_SUM:
        begin
          nxt_value = sum_ff;
          nxt_unit  = ofm_pkg::UNIT_L;
        end
        ofm_pkg::MODE_TOTAL:
        begin
          nxt_value = tot_ff;
          nxt_unit  = ofm_pkg::UNIT_L;
        end
        ofm_pkg::MODE_HRS1:
        begin
          nxt_value = hrs1_ff;
          nxt_unit  = ofm_pkg::UNIT_H;
        end
        ofm_pkg::MODE_HRS2:
        begin
          nxt_value = hrs2_ff;
          nxt_unit  = ofm_pkg::UNIT_H;
        end
        ofm_pkg::MODE_STARTS1:
          nxt_value = st1_ff;
        ofm_pkg::MODE_STARTS2:
          nxt_value = st2_ff;
        ofm_pkg::MODE_SVC:
        begin
          nxt_value = nom_act;
          nxt_unit  = ofm_pkg::UNIT_LPH;
          nxt_dec2  = 1'b1;
        end
        ofm_pkg::MODE_BATT:
          nxt_value = 20'h0;
        default:
          nxt_value = 20'h0;
      endcase
    end
  end

  // leading zero blanking; with two decimals the last three always show
  for (genvar d = 0; d < 6; d++)
  begin : g_digit
    localparam logic [19:0] POW = 20'(10 ** d);
    assign nxt_digit_on[d] = disp_lit &&
                             !((blink_hold || confirming) && !tk.blink) &&
                             (d == 0 || nxt_value >= POW ||
                              (nxt_dec2 && d <= 2));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      disp_value_ff <= 20'h0;
      digit_on_ff   <= 6'h0;
      dec2_ff       <= 1'b0;
      unit_ff       <= ofm_pkg::UNIT_LPH;
      svc_sym_ff    <= 1'b0;
      batt_sym_ff   <= 1'b0;
    end
    else
    begin
      disp_value_ff <= nxt_value;
      digit_on_ff   <= nxt_digit_on;
      dec2_ff       <= nxt_dec2;
      unit_ff       <= nxt_unit;
      svc_sym_ff    <= disp_lit && (confirming ? tk.blink
                                               : svc_ff);
      batt_sym_ff   <= disp_lit && batt_var && batt_low;
    end
  end

  // battery data hold needs no logic: flops keep state while pclk runs
  assign disp_value = disp_value_ff;
  assign digit_on   = digit_on_ff;
  assign dec2       = dec2_ff;
  assign disp_unit  = unit_ff;
  assign mode_sym   = disp_lit ? mode_ff : 10'h0;
  assign svc_sym    = svc_sym_ff;
  assign batt_sym   = batt_sym_ff;

  // apb: zero wait states, error on unmapped or read-only writes
  assign apb_access = psel && penable;
  assign hit        = paddr[1:0] == 2'h0 && paddr <= ofm_pkg::OFS_STARTS2;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= ofm_pkg::CTRL_RESET;
    else if (apb_access && pwrite && paddr == ofm_pkg::OFS_CTRL)
      ctrl_ff <= pwdata[2:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr_ff <= !hit || (pwrite && paddr != ofm_pkg::OFS_CTRL);
      unique case (paddr)
        ofm_pkg::OFS_CTRL:    prdata_ff <= {29'h0, ctrl_ff};
        ofm_pkg::OFS_STATUS:  prdata_ff <= {19'h0, batt_sym_ff, svc_ff,
                                            ~disp_lit, mode_ff};
        ofm_pkg::OFS_FLOW:    prdata_ff <= {12'h0, flow_ff};
        ofm_pkg::OFS_NOM1:    prdata_ff <= {12'h0, nom1_ff};
        ofm_pkg::OFS_NOM2:    prdata_ff <= {12'h0, nom2_ff};
        ofm_pkg::OFS_SUMVOL:  prdata_ff <= {12'h0, sum_ff};
        ofm_pkg::OFS_TOTVOL:  prdata_ff <= {12'h0, tot_ff};
        ofm_pkg::OFS_HOURS1:  prdata_ff <= {12'h0, hrs1_ff};
        ofm_pkg::OFS_HOURS2:  prdata_ff <= {12'h0, hrs2_ff};
        ofm_pkg::OFS_STARTS1: prdata_ff <= {12'h0, st1_ff};
        ofm_pkg::OFS_STARTS2: prdata_ff <= {12'h0, st2_ff};
        default:              prdata_ff <= 32'h0;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff & apb_access;

endmodule

// [testbench/ofm_chk_checker.sv]
// Purpose: port checks for ofm_top
// Assumes: single pclk domain
// Notes:   repeats skip values held over from reset
`timescale 1ns/1ps
module ofm_chk (
  // clock and reset
  input logic        pclk,
  input logic        presetn,
  // apb
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        pready,
  input logic        pslverr,
  // button and display
  input logic        button_n,
  input logic [19:0] disp_value,
  input logic [5:0]  digit_on,
  input logic        dec2,
  input logic [1:0]  disp_unit,
  input logic [9:0]  mode_sym
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  no_wait_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("stray error");
  ro_write_a: assert property (psel && penable && pwrite &&
    paddr != 8'h00 |-> pslverr) else $error("write not refused");
  align_err_a: assert property (psel && penable &&
    paddr[1:0] != 2'h0 |-> pslverr) else $error("unaligned taken");
  one_mode_a: assert property ($onehot0(mode_sym))
    else $error("mode symbol not one-hot");
  hold_mode_a: assert property ((!button_n) [*3] |-> $stable(mode_sym))
    else $error("mode moved while held");
  lead_zero_a: assert property (digit_on[3] |-> disp_value > 20'd999)
    else $error("leading zero lit");
  sum_unit_a: assert property (mode_sym[2] [*3]
    |-> !dec2 && disp_unit == 2'h1) else $error("sum unit wrong");
  flow_unit_a: assert property (mode_sym[0] [*3]
    |-> dec2 && disp_unit == 2'h0) else $error("flow unit wrong");
endmodule

// [testbench/ofm_sensor_model.sv]
// Purpose: flow sensor stand-in, one pulse per period
// Assumes: period in pclk cycles, 0 stops the wheel
// Notes:   line is driven low between pulses
`timescale 1ns/1ps
module ofm_sensor_model (
  // clock
  input logic  pclk,
  // rate
  input int    period,
  // sensor line
  output logic flow_pulse
);
  int cnt = 0;
  initial flow_pulse = 1'b0;
  always @(posedge pclk)
  begin
    cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
    flow_pulse <= period > 0 && cnt == 0;
  end
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench for ofm_top
// Assumes: one second is 8 pclk cycles (HALF_CYC 4)
// Notes:   short second and hour keep every hold under 300 cycles
`timescale 1ns/1ps
module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic        penable = 1'b0, pwrite = 1'b0, button_n = 1'b1;
  logic        stage1_run = 1'b0, mains_ok = 1'b1, re;
  logic        stage2_run = 1'b0, batt_low = 1'b0;
  logic        pready, pslverr, flow_pulse, dec2, svc_sym, batt_sym;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rq, s0, t0;
  logic [19:0] disp_value;
  logic [5:0]  digit_on;
  logic [1:0]  disp_unit;
  logic [9:0]  mode_sym, m;
  logic [2:0]  cfg [3] = '{3'h0, 3'h2, 3'h1};
  int          period = 0, seed = 74364, err_total = 0;
  int          samples_checked = 0;
  // short second keeps 30 s holds near 240 cycles
  ofm_top #(.HALF_CYC(4), .BLANK_S(100), .PULSE_PER_L(4),
    .FLOW_WIN_S(2), .SEC_PER_HOUR(3)) uut (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .flow_pulse, .button_n, .stage1_run, .stage2_run, .mains_ok,
    .batt_low, .disp_value, .digit_on, .dec2, .disp_unit,
    .mode_sym, .svc_sym, .batt_sym);
  ofm_sensor_model sensor (.pclk, .period, .flow_pulse);
  initial forever #5 pclk = ~pclk;
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rq, exp);
  endtask
  // press for cyc cycles; display settles 2 edges after release
  task automatic hold(input int cyc);
    button_n <= 1'b0;
    repeat (cyc) @(posedge pclk);
    button_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic home();
    while (mode_sym !== 10'h001) hold(2);
  endtask
  function automatic logic [9:0] next_sym(logic [9:0] s, logic [9:0] k);
    do s = s[9] ? 10'h001 : s << 1; while ((s & k) == 10'h000);
    return s;
  endfunction
  // pulses seen in one two-second window of 16 cycles
  function automatic logic [31:0] exp_flow(int p);
    return 32'(16 / p);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(8'h00, 32'h0);
    apb(8'h00, 1'b1, 32'h5);
    rdchk(8'h00, 32'h5);
    rdchk(8'h2c, 32'h0);
    chk({31'h0, re}, 32'h1);
    apb(8'h04, 1'b1, 32'h0);
    chk({31'h0, re}, 32'h1);
    $display("test registers done");
    m = 10'h001;
    foreach (cfg[i])
    begin
      apb(8'h00, 1'b1, {29'h0, cfg[i]});
      repeat (3 + ($random(seed) & 7))
      begin
        hold(2);
        m = next_sym(m, cfg[i][0] ? 10'h3ff : 10'h31d);
        chk({22'h0, mode_sym}, {22'h0, m});
        apb(8'h04, 1'b0, 32'h0);
        chk({22'h0, rq[9:0]}, {22'h0, m});
      end
      home();
      m = 10'h001;
    end
    $display("test modes done");
    apb(8'h00, 1'b1, 32'h0);
    hold(2);
    period <= 2 << ($random(seed) & 1);
    repeat (200) @(posedge pclk);
    period <= 0;
    repeat (8) @(posedge pclk);
    apb(8'h14, 1'b0, 32'h0);
    s0 = rq;
    apb(8'h18, 1'b0, 32'h0);
    t0 = rq;
    chk({31'h0, s0 == 0}, 32'h0);
    mains_ok <= 1'b0;
    hold(96);
    mains_ok <= 1'b1;
    rdchk(8'h14, s0);
    hold(56);
    rdchk(8'h14, s0);
    chk({22'h0, mode_sym}, 32'h4);
    hold(96);
    rdchk(8'h14, 32'h0);
    chk({12'h0, disp_value}, 32'h0);
    chk({26'h0, digit_on}, 32'h1);
    rdchk(8'h18, t0);
    $display("test sum done");
    home();
    stage1_run <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      period <= i ? 2 : 4 << ($random(seed) & 1);
      repeat (40) @(posedge pclk);
      hold(244);
      rdchk(8'h08, exp_flow(period));
      rdchk(8'h0c, exp_flow(period));
      chk({22'h0, mode_sym}, 32'h1);
      repeat (48) @(posedge pclk);
    end
    period <= 8;
    repeat (56) @(posedge pclk);
    chk({31'h0, svc_sym}, 32'h1);
    hold(272);
    rdchk(8'h0c, 32'h0);
    repeat (48) @(posedge pclk);
    chk({31'h0, svc_sym}, 32'h0);
    $display("test preset done");
    apb(8'h00, 1'b1, 32'h4);
    batt_low   <= 1'b1;
    stage2_run <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, batt_sym}, 32'h1);
    batt_low <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, batt_sym}, 32'h0);
    rdchk(8'h24, 32'h1);
    rdchk(8'h28, 32'h1);
    apb(8'h00, 1'b1, 32'h0);
    mains_ok <= 1'b0;
    repeat (816) @(posedge pclk);
    chk({26'h0, digit_on}, 32'h0);
    mains_ok <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({22'h0, mode_sym}, 32'h1);
    $display("test power done");
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
endmodule
bind ofm_top ofm_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pready, .pslverr, .button_n, .disp_value, .digit_on, .dec2,
  .disp_unit, .mode_sym);
